// ### lam_line_alarm_monitor.sv
// T1/J1 receive alarm monitor (blue, yellow, red) with an AHB-Lite register slave
// assumes the framer presents received bits and position strobes synchronous to hclk
// Functional notes
// - blue declared after N consecutive windows each with fewer than 61 zeros.
// - blue cleared after M consecutive windows each with more than 60 zeros.
// - yellow is evaluated only while the framer reports frame sync.
// - T1 SF/SLC-96: fewer than 77 bit-2 ones for N windows declares yellow.
// - T1 SF/SLC-96: more than 76 bit-2 ones for M windows clears yellow.
// - T1 ESF: more than 7 ff00 patterns on link bits for N windows declares.
// - T1 ESF: fewer than 8 ff00 patterns for M windows clears yellow.
// - T1 digital mux: fewer than 4 Y-bit ones for N windows declares.
// - T1 digital mux: more than 3 Y-bit ones for M windows clears.
// - J1 SF: fewer than 4 zeros on frame-12 F-bit for N windows declares.
// - J1 SF: more than 3 zeros on frame-12 F-bit for M windows clears.
// - J1 ESF: fewer than 3 zeros on link bits for N windows declares.
// - J1 ESF: more than 2 zeros on link bits for M windows clears.
// - red declared when frame loss lasts N times 40 ms.
// - red cleared when frame sync holds M times 120 ms.
// - any change of an alarm sets its sticky change flag.
// - writing one clears a change flag; zero leaves it.
// - interrupt pin low when an enabled change flag is set.
//
// Decided for this implementation: the AHB-Lite slave port.
`include "lam_map.svh"
`default_nettype none
module lam_line_alarm_monitor
	import lam_pkg::*;
#(
	parameter int unsigned WIN_CYC = `LAM_WIN_MS * 1000000 / `LAM_CLK_NS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq_n,
	input wire logic rx_bit_vld,
	input wire logic rx_bit,
	input wire logic rx_is_bit2,
	input wire logic rx_is_ybit,
	input wire logic rx_is_f12,
	input wire logic rx_is_link,
	input wire logic rx_in_frame
);
	localparam logic [9:0] RED_RATIO = 10'(`LAM_RED_CLR_MS / `LAM_WIN_MS);

	logic [2:0] en_ff, nxt_en, flag_ff, nxt_flag, al_st, nxt_al;
	// thresholds count whole windows (red clearing in threes); a value of zero means one window
	logic [7:0] red_dec_ff, nxt_red_dec, red_cl_ff, nxt_red_cl;
	logic [7:0] yel_dec_ff, nxt_yel_dec, yel_cl_ff, nxt_yel_cl;
	logic [7:0] blu_dec_ff, nxt_blu_dec, blu_cl_ff, nxt_blu_cl;
	lam_fmt_e fmt_ff, nxt_fmt;
	logic dp_wr_ff, nxt_dp_wr;
	logic [7:0] dp_idx_ff, nxt_dp_idx, rd_idx;
	logic [31:0] hrdata_ff, nxt_rdata;
	logic hreadyout_ff, hresp_ff, irq_n_ff, nxt_irq_n, ap;

	logic [31:0] wc_ff, nxt_wc;
	logic [7:0] zc_ff, nxt_zc, yc_ff, nxt_yc;
	logic [15:0] sr_ff, nxt_sr;
	logic wsync_ff, nxt_wsync, win_end, yinc, ydec, yclr;

	logic red_ff, nxt_red;
	logic [9:0] rc_ff, nxt_rc, rc1, rlim;

	logic [1:0][7:0] dlim, clim;
	logic [1:0] dec, clr, evl, st, nxt_st;

	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = hresp_ff;
	assign irq_n = irq_n_ff;

	function automatic logic [7:0] sat_inc(input logic [7:0] c, input logic inc);
		sat_inc = (inc && c != 8'hff) ? c + 8'h01 : c;
	endfunction : sat_inc

	// bus slave and registers; read data of all but the state register comes from next values so a read
	// right behind a write to the same register already sees the write
	assign ap = hsel & htrans[1] & hready;
	assign rd_idx = haddr[`LAM_IDX_MSB:`LAM_IDX_LSB];
	assign al_st = {st[0], st[1], red_ff};
	assign nxt_al = {nxt_st[0], nxt_st[1], nxt_red};

	always_comb begin
		nxt_dp_wr = ap & hwrite;
		nxt_dp_idx = rd_idx;
		nxt_en = en_ff;
		nxt_red_dec = red_dec_ff;
		nxt_red_cl = red_cl_ff;
		nxt_yel_dec = yel_dec_ff;
		nxt_yel_cl = yel_cl_ff;
		nxt_blu_dec = blu_dec_ff;
		nxt_blu_cl = blu_cl_ff;
		nxt_fmt = fmt_ff;
		nxt_flag = flag_ff;
		if (dp_wr_ff) begin
			case (dp_idx_ff)
				`LAM_IDX_IRQ_EN: nxt_en = hwdata[2:0];
				`LAM_IDX_FLAGS: nxt_flag = flag_ff & ~hwdata[2:0];
				`LAM_IDX_RED_DEC: nxt_red_dec = hwdata[7:0];
				`LAM_IDX_RED_CL: nxt_red_cl = hwdata[7:0];
				`LAM_IDX_YEL_DEC: nxt_yel_dec = hwdata[7:0];
				`LAM_IDX_YEL_CL: nxt_yel_cl = hwdata[7:0];
				`LAM_IDX_BLU_DEC: nxt_blu_dec = hwdata[7:0];
				`LAM_IDX_BLU_CL: nxt_blu_cl = hwdata[7:0];
				`LAM_IDX_FORMAT: nxt_fmt = lam_fmt_e'(hwdata[2:0]);
				default: ;
			endcase
		end
		// a change in the clearing cycle still lands in the flag
		nxt_flag = nxt_flag | (nxt_al ^ al_st);
		nxt_irq_n = ~|(nxt_flag & nxt_en);
		nxt_rdata = hrdata_ff;
		if (ap && !hwrite) begin
			case (rd_idx)
				`LAM_IDX_STATE: nxt_rdata = {29'h0, al_st};
				`LAM_IDX_IRQ_EN: nxt_rdata = {29'h0, nxt_en};
				`LAM_IDX_FLAGS: nxt_rdata = {29'h0, nxt_flag};
				`LAM_IDX_RED_DEC: nxt_rdata = {24'h0, nxt_red_dec};
				`LAM_IDX_RED_CL: nxt_rdata = {24'h0, nxt_red_cl};
				`LAM_IDX_YEL_DEC: nxt_rdata = {24'h0, nxt_yel_dec};
				`LAM_IDX_YEL_CL: nxt_rdata = {24'h0, nxt_yel_cl};
				`LAM_IDX_BLU_DEC: nxt_rdata = {24'h0, nxt_blu_dec};
				`LAM_IDX_BLU_CL: nxt_rdata = {24'h0, nxt_blu_cl};
				`LAM_IDX_FORMAT: nxt_rdata = {29'h0, nxt_fmt};
				default: nxt_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_ff <= 1'b0;
			dp_idx_ff <= 8'h00;
			en_ff <= 3'h0;
			flag_ff <= 3'h0;
			red_dec_ff <= `LAM_RST_RED_DEC;
			red_cl_ff <= `LAM_RST_RED_CL;
			yel_dec_ff <= `LAM_RST_YEL_DEC;
			yel_cl_ff <= `LAM_RST_YEL_CL;
			blu_dec_ff <= `LAM_RST_BLU_DEC;
			blu_cl_ff <= `LAM_RST_BLU_CL;
			fmt_ff <= LAM_T1_SF;
			hrdata_ff <= 32'h0;
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
			irq_n_ff <= 1'b1;
		end else begin
			dp_wr_ff <= nxt_dp_wr;
			dp_idx_ff <= nxt_dp_idx;
			en_ff <= nxt_en;
			flag_ff <= nxt_flag;
			red_dec_ff <= nxt_red_dec;
			red_cl_ff <= nxt_red_cl;
			yel_dec_ff <= nxt_yel_dec;
			yel_cl_ff <= nxt_yel_cl;
			blu_dec_ff <= nxt_blu_dec;
			blu_cl_ff <= nxt_blu_cl;
			fmt_ff <= nxt_fmt;
			hrdata_ff <= nxt_rdata;
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
			irq_n_ff <= nxt_irq_n;
		end
	end

	// 40 ms fixed windows; the bit seen in the closing cycle opens the next window
	assign win_end = (wc_ff == WIN_CYC - 1);

	always_comb begin
		nxt_sr = sr_ff;
		// the link-bit history survives window ends, so a pattern may straddle two windows
		if (rx_bit_vld && rx_is_link) begin
			nxt_sr = {sr_ff[14:0], rx_bit};
		end
		case (fmt_ff)
			LAM_T1_ESF: yinc = rx_bit_vld & rx_is_link & (nxt_sr == `LAM_ESF_PAT);
			LAM_T1_DIGMUX: yinc = rx_bit_vld & rx_is_ybit & rx_bit;
			LAM_J1_SF: yinc = rx_bit_vld & rx_is_f12 & ~rx_bit;
			LAM_J1_ESF: yinc = rx_bit_vld & rx_is_link & ~rx_bit;
			default: yinc = rx_bit_vld & rx_is_bit2 & rx_bit;
		endcase
		nxt_wc = win_end ? 32'h0 : wc_ff + 32'h1;
		nxt_zc = sat_inc(win_end ? 8'h00 : zc_ff, rx_bit_vld & ~rx_bit);
		nxt_yc = sat_inc(win_end ? 8'h00 : yc_ff, yinc & rx_in_frame);
		nxt_wsync = (win_end | wsync_ff) & rx_in_frame;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wc_ff <= 32'h0;
			zc_ff <= 8'h00;
			yc_ff <= 8'h00;
			sr_ff <= 16'h0;
			wsync_ff <= 1'b0;
		end else begin
			wc_ff <= nxt_wc;
			zc_ff <= nxt_zc;
			yc_ff <= nxt_yc;
			sr_ff <= nxt_sr;
			wsync_ff <= nxt_wsync;
		end
	end

	// window verdicts; a window that lost sync anywhere counts as failing for yellow
	always_comb begin
		case (fmt_ff)
			LAM_T1_ESF: begin
				ydec = yc_ff > `LAM_ESF_DEC_GT;
				yclr = yc_ff < `LAM_ESF_CL_LT;
			end
			LAM_T1_DIGMUX: begin
				ydec = yc_ff < `LAM_MUX_DEC_LT;
				yclr = yc_ff > `LAM_MUX_CL_GT;
			end
			LAM_J1_SF: begin
				ydec = yc_ff < `LAM_J1SF_DEC_LT;
				yclr = yc_ff > `LAM_J1SF_CL_GT;
			end
			LAM_J1_ESF: begin
				ydec = yc_ff < `LAM_J1ESF_DEC_LT;
				yclr = yc_ff > `LAM_J1ESF_CL_GT;
			end
			// unused codes fall back to superframe counting rather than freezing yellow
			default: begin
				ydec = yc_ff < `LAM_SF_DEC_LT;
				yclr = yc_ff > `LAM_SF_CL_GT;
			end
		endcase
	end

	assign dec = {ydec, zc_ff < `LAM_BLU_DEC_LT};
	assign clr = {yclr, zc_ff > `LAM_BLU_CL_GT};
	// blue looks at raw zeros and needs no framing, so it is always evaluated
	assign evl = {wsync_ff & rx_in_frame, 1'b1};
	assign dlim = {yel_dec_ff, blu_dec_ff};
	assign clim = {yel_cl_ff, blu_cl_ff};

	// index 0 is blue, index 1 is yellow
	for (genvar i = 0; i < 2; i++) begin : g_al
		logic st_ff;
		logic [7:0] pc_ff, nxt_pc;
		logic [8:0] pc1;
		// a local next-state bit keeps each process the only writer of its variable
		logic nxt_s;
		assign st[i] = st_ff;
		assign nxt_st[i] = nxt_s;
		always_comb begin
			pc1 = {1'b0, pc_ff} + 9'h001;
			nxt_s = st_ff;
			nxt_pc = pc_ff;
			if (win_end) begin
				if (evl[i] && (st_ff ? clr[i] : dec[i])) begin
					if (pc1 >= {1'b0, st_ff ? clim[i] : dlim[i]}) begin
						nxt_s = ~st_ff;
						nxt_pc = 8'h00;
					end else begin
						nxt_pc = pc1[7:0];
					end
				end else begin
					nxt_pc = 8'h00;
				end
			end
		end
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				st_ff <= 1'b0;
				pc_ff <= 8'h00;
			end else begin
				st_ff <= nxt_s;
				pc_ff <= nxt_pc;
			end
		end
	end

	// red counts whole window ticks while the sync state opposes the alarm;
	// any tick-free flip back of sync restarts the count
	assign rc1 = rc_ff + 10'h001;
	// clearing counts three window ticks per unit; ten bits hold the largest product
	assign rlim = red_ff ? 10'({2'b00, red_cl_ff} * RED_RATIO) : {2'b00, red_dec_ff};

	always_comb begin
		nxt_red = red_ff;
		nxt_rc = rc_ff;
		if (red_ff != rx_in_frame) begin
			nxt_rc = 10'h000;
		end else if (win_end) begin
			if (rc1 >= rlim) begin
				nxt_red = ~red_ff;
				nxt_rc = 10'h000;
			end else begin
				nxt_rc = rc1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			red_ff <= 1'b0;
			rc_ff <= 10'h000;
		end else begin
			red_ff <= nxt_red;
			rc_ff <= nxt_rc;
		end
	end

	// all checks run on hclk and rest while reset is low
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	AST_BLUE_DECL: assert property ($rose(st[0]) |-> $past(win_end && zc_ff < `LAM_BLU_DEC_LT))
		else $error("blue declared without a low-zero window");
	AST_BLUE_CLR: assert property ($fell(st[0]) |-> $past(win_end && zc_ff > `LAM_BLU_CL_GT))
		else $error("blue cleared without a high-zero window");
	AST_YEL_SYNC: assert property ($changed(st[1]) |-> $past(win_end && wsync_ff && rx_in_frame))
		else $error("yellow changed outside an in-frame window");
	AST_YEL_DECL: assert property ($rose(st[1]) |-> $past(ydec))
		else $error("yellow declared without a declare verdict");
	AST_YEL_CLR: assert property ($fell(st[1]) |-> $past(win_end && yclr))
		else $error("yellow cleared without a clear verdict");
	AST_RED_DECL: assert property ($rose(red_ff) |-> $past(win_end && !rx_in_frame && rc1 >= rlim))
		else $error("red declared early or in frame");
	AST_RED_CLR: assert property ($fell(red_ff) |-> $past(win_end && rx_in_frame))
		else $error("red cleared without frame sync");
	AST_FLAG_SET: assert property ($changed(al_st) |-> (flag_ff & (al_st ^ $past(al_st))) != 3'h0)
		else $error("alarm change left no flag");
	AST_W1C: assert property (dp_wr_ff && dp_idx_ff == `LAM_IDX_FLAGS && nxt_al == al_st
		|=> (flag_ff & $past(hwdata[2:0])) == 3'h0 && (flag_ff | $past(hwdata[2:0])) >= $past(flag_ff))
		else $error("flag write-one-to-clear misbehaved");
	AST_IRQ: assert property (##1 irq_n == !(|($past(nxt_flag) & $past(nxt_en))))
		else $error("interrupt pin disagrees with enabled flags");
	AST_PERSIST: assert property (win_end && !evl[1] |=> g_al[1].pc_ff == 8'h00)
		else $error("yellow count kept across a failing window");

	COV_BLUE: cover property ($rose(st[0]));
	COV_YEL_ESF: cover property (fmt_ff == LAM_T1_ESF && $rose(st[1]));
	COV_RED_CLR: cover property ($fell(red_ff));
	COV_IRQ: cover property ($fell(irq_n));
	COV_YEL_MUX: cover property (fmt_ff == LAM_T1_DIGMUX && $fell(st[1]));
endmodule : lam_line_alarm_monitor
`default_nettype wire

// ### lam_map.svh
// register map, reset values, thresholds and timing of the line alarm monitor
// assumes a 100 MHz bus clock; included by bare name
`ifndef LAM_MAP_SVH
`define LAM_MAP_SVH
`define LAM_IDX_LSB 2
`define LAM_IDX_MSB 9
`define LAM_IDX_STATE 8'hb9
`define LAM_IDX_IRQ_EN 8'hba
`define LAM_IDX_FLAGS 8'hbb
`define LAM_IDX_RED_DEC 8'hbc
`define LAM_IDX_RED_CL 8'hbd
`define LAM_IDX_YEL_DEC 8'hbe
`define LAM_IDX_YEL_CL 8'hbf
`define LAM_IDX_BLU_DEC 8'hc0
`define LAM_IDX_BLU_CL 8'hc1
`define LAM_IDX_FORMAT 8'hc8
`define LAM_RST_RED_DEC 8'h3f
`define LAM_RST_RED_CL 8'h7f
`define LAM_RST_YEL_DEC 8'h0a
`define LAM_RST_YEL_CL 8'h0a
`define LAM_RST_BLU_DEC 8'h3f
`define LAM_RST_BLU_CL 8'h3f
`define LAM_BIT_BLUE 2
`define LAM_BIT_YEL 1
`define LAM_BIT_RED 0
`define LAM_CLK_NS 10
`define LAM_WIN_MS 40
`define LAM_RED_CLR_MS 120
`define LAM_BLU_DEC_LT 8'd61
`define LAM_BLU_CL_GT 8'd60
`define LAM_SF_DEC_LT 8'd77
`define LAM_SF_CL_GT 8'd76
`define LAM_ESF_DEC_GT 8'd7
`define LAM_ESF_CL_LT 8'd8
`define LAM_ESF_PAT 16'hff00
`define LAM_MUX_DEC_LT 8'd4
`define LAM_MUX_CL_GT 8'd3
`define LAM_J1SF_DEC_LT 8'd4
`define LAM_J1SF_CL_GT 8'd3
`define LAM_J1ESF_DEC_LT 8'd3
`define LAM_J1ESF_CL_GT 8'd2
`endif

// ### lam_pkg.sv
// types shared by the line alarm monitor
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package lam_pkg;
	typedef enum logic [2:0] {
		LAM_T1_SF,
		LAM_T1_SLC96,
		LAM_T1_ESF,
		LAM_T1_DIGMUX,
		LAM_J1_SF,
		LAM_J1_ESF
	} lam_fmt_e;
endpackage : lam_pkg
`default_nettype wire

// ### lam_fm_model.sv
// framer stand-in: per window a run of marked bits carries the counted value, the rest its opposite
// assumes its window count restarts with the monitor's at reset release
`default_nettype none
module lam_fm_model #(
	parameter int unsigned W = 200
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [13:0] cfg,
	output logic tick,
	output logic rx_bit_vld,
	output logic rx_bit,
	output logic rx_is_bit2,
	output logic rx_is_ybit,
	output logic rx_is_f12,
	output logic rx_is_link,
	output logic rx_in_frame
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cnt_ff;
	logic [13:0] cur_ff;
	logic [7:0] idx;
	logic mark;
	assign tick = (cnt_ff == 16'(W - 1));
	assign idx = cnt_ff[7:0] - 8'h0a;
	assign mark = (cnt_ff >= 16'h000a) && (idx < cur_ff[13:6]);
	// settings apply from a window start only, so no window mixes two patterns
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= 16'h0000;
			cur_ff <= 14'h0001;
		end else begin
			cnt_ff <= tick ? 16'h0000 : cnt_ff + 16'h0001;
			if (cnt_ff == 16'h0000) begin
				cur_ff <= cfg;
			end
		end
	end
	assign rx_bit_vld = 1'b1;
	// pattern mode: eight ones then eight zeros, one ff00 match per sixteen link bits
	assign rx_bit = mark ? (cur_ff[1] ? ~idx[3] : cur_ff[2]) : ~cur_ff[2];
	assign rx_is_bit2 = mark && (cur_ff[5:3] == 3'h1);
	assign rx_is_ybit = mark && (cur_ff[5:3] == 3'h2);
	assign rx_is_f12 = mark && (cur_ff[5:3] == 3'h3);
	assign rx_is_link = mark && (cur_ff[5:3] == 3'h4);
	assign rx_in_frame = cur_ff[0];
endmodule : lam_fm_model
`default_nettype wire

// ### tb_top.sv
// bench for the line alarm monitor: registers, persistence per format, red timing, flags, irq pin
// assumes lam_fm_model as framer and windows shortened to 200 cycles
`include "lam_map.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned W = 200;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [13:0] cfg = {8'd100, 6'b000001};
	logic [31:0] hrdata, rd;
	logic hready, hresp, irq_n, tick, vld, rbit, b2, yb, f12, lnk, inf;
	int n_errors = 0;
	int checks_done = 0;
	logic [7:0] ridx [11] = '{`LAM_IDX_STATE, `LAM_IDX_IRQ_EN, `LAM_IDX_FLAGS, `LAM_IDX_RED_DEC, `LAM_IDX_RED_CL,
		`LAM_IDX_YEL_DEC, `LAM_IDX_YEL_CL, `LAM_IDX_BLU_DEC, `LAM_IDX_BLU_CL, `LAM_IDX_FORMAT, 8'h10};
	logic [7:0] rrst [11] = '{8'h00, 8'h00, 8'h00, `LAM_RST_RED_DEC, `LAM_RST_RED_CL, `LAM_RST_YEL_DEC,
		`LAM_RST_YEL_CL, `LAM_RST_BLU_DEC, `LAM_RST_BLU_CL, 8'h00, 8'h00};
	logic [7:0] rmsk [11] = '{8'h00, 8'h07, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h07, 8'h00};
	// per format: qualifier, counted value, pattern mode, in frame; then declaring and clearing counts
	logic [5:0] yq [6] = '{6'b001101, 6'b001101, 6'b100111, 6'b010101, 6'b011001, 6'b100001};
	logic [7:0] ydl [6] = '{8'd0, 8'd76, 8'd128, 8'd3, 8'd3, 8'd2};
	logic [7:0] ycl [6] = '{8'd0, 8'd77, 8'd112, 8'd4, 8'd4, 8'd3};
	always #5 hclk = ~hclk;
	lam_line_alarm_monitor #(.WIN_CYC(W)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .irq_n(irq_n), .rx_bit_vld(vld), .rx_bit(rbit), .rx_is_bit2(b2),
		.rx_is_ybit(yb), .rx_is_f12(f12), .rx_is_link(lnk), .rx_in_frame(inf));
	lam_fm_model #(.W(W)) FM (.hclk(hclk), .hresetn(hresetn), .cfg(cfg), .tick(tick), .rx_bit_vld(vld),
		.rx_bit(rbit), .rx_is_bit2(b2), .rx_is_ybit(yb), .rx_is_f12(f12), .rx_is_link(lnk), .rx_in_frame(inf));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	task automatic cmp(input logic [31:0] got, input logic [31:0] e);
		checks_done++;
		if (got !== e) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask : cmp
	task automatic cmp_irq(input logic e);
		@(negedge hclk);
		cmp({31'h0, irq_n}, {31'h0, e});
		@(posedge hclk);
	endtask : cmp_irq
	task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'b00};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic rdc(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
		ahb(1'b0, idx, 32'h0);
		cmp(rd & m, e);
	endtask : rdc
	task automatic wins(input int k);
		repeat (k) begin
			do @(posedge hclk); while (tick !== 1'b1);
		end
	endtask : wins
	// k+1 ends: the running window keeps the old pattern; the new one also fills the window after
	// the last end, so a pattern set here is judged k times now and once more at the next step
	task automatic step(input logic [13:0] c, input int k);
		@(posedge hclk);
		cfg <= c;
		wins(k + 1);
	endtask : step
	task automatic persist(input logic [5:0] q, input logic [7:0] nd, input logic [7:0] nc, input logic [31:0] m);
		step({nc, q}, 3);
		rdc(`LAM_IDX_STATE, m, 32'h0);
		step({nd, q}, 0);
		step({nc, q}, 0);
		step({nd, q}, 0);
		step({nc, q}, 0);
		rdc(`LAM_IDX_STATE, m, 32'h0);
		step({nd, q}, 2);
		rdc(`LAM_IDX_STATE, m, m);
		step({nc, q}, 1);
		rdc(`LAM_IDX_STATE, m, m);
		step({nc, q}, 1);
		rdc(`LAM_IDX_STATE, m, 32'h0);
	endtask : persist
	initial begin
		void'($urandom(17840));
		ydl[0] = 8'($urandom_range(76));
		ycl[0] = 8'($urandom_range(150, 77));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 11; i++) rdc(ridx[i], 32'hffffffff, {24'h0, rrst[i]});
		for (int i = 0; i < 11; i++) begin
			ahb(1'b1, ridx[i], $urandom);
			rdc(ridx[i], 32'hffffffff, {24'h0, hwdata[7:0] & rmsk[i]});
		end
		for (int i = 3; i < 9; i++) ahb(1'b1, ridx[i], (i == 4) ? 32'h1 : 32'h2);
		ahb(1'b1, `LAM_IDX_IRQ_EN, 32'h0);
		ahb(1'b1, `LAM_IDX_FORMAT, 32'h0);
		ahb(1'b1, `LAM_IDX_FLAGS, 32'h7);
		$display("test registers done");
		persist(6'b000001, 8'd60, 8'd61, 32'h4);
		rdc(`LAM_IDX_FLAGS, 32'h4, 32'h4);
		cmp_irq(1'b1);
		ahb(1'b1, `LAM_IDX_IRQ_EN, 32'h4);
		cmp_irq(1'b0);
		ahb(1'b1, `LAM_IDX_FLAGS, 32'h0);
		rdc(`LAM_IDX_FLAGS, 32'h4, 32'h4);
		ahb(1'b1, `LAM_IDX_FLAGS, 32'h4);
		cmp_irq(1'b1);
		$display("test blue and flags done");
		for (int f = 0; f < 6; f++) begin
			ahb(1'b1, `LAM_IDX_FORMAT, 32'(f));
			persist(yq[f], ydl[f], ycl[f], 32'h2);
		end
		$display("test yellow done");
		step({8'd2, 6'b100000}, 1);
		rdc(`LAM_IDX_STATE, 32'h3, 32'h0);
		step({8'd2, 6'b100000}, 1);
		rdc(`LAM_IDX_STATE, 32'h3, 32'h1);
		step({8'd3, 6'b100001}, 2);
		rdc(`LAM_IDX_STATE, 32'h1, 32'h1);
		step({8'd3, 6'b100001}, 1);
		rdc(`LAM_IDX_STATE, 32'h1, 32'h0);
		$display("test red done");
		complete_run();
	end
	initial begin
		#1000000;
		n_errors++;
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
